// ### bench/ocmp_load.sv
`timescale 1ns/1ps
// ****
// Pin load: measures pin edges and irq lag in clk_sys cycles
// ****
module ocmp_load (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Observed lines
  input wire logic pin,
  input wire logic irq,
  // Measurements
  output int edges,
  output int gap,
  output int irq_lag
);
  int cyc; // Free cycle count
  int last; // Cycle of last pin edge
  logic pin_d; // Delayed pin
  logic irq_d; // Delayed irq
  // Edge and lag timing
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc <= 0;
      last <= 0;
      edges <= 0;
      gap <= 0;
      irq_lag <= 0;
      pin_d <= 1'b0;
      irq_d <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 1;
      pin_d <= pin;
      irq_d <= irq;
      // Pin changed level
      if (pin !== pin_d)
      begin
        edges <= edges + 1;
        gap <= cyc - last;
        last <= cyc;
      end
      // Irq rose
      if (irq === 1'b1 && irq_d !== 1'b1)
        irq_lag <= cyc - last;
    end
  end
endmodule

// ### bench/test_compare_toggle_single_pulse.sv
`timescale 1ns/1ps
`include "ocmp_defines.svh"
// ****
// Bench for the compare channel
// ****
module test_compare_toggle_single_pulse;
  import ocmp_pkg::*;
  logic clk_sys; // System clock
  logic reset_n; // Reset, active low
  ocmp_req_t req; // Bus request
  ocmp_rsp_t rsp; // Bus answer
  logic pin; // Compare output
  logic irq; // Interrupt request
  int edges, gap, irq_lag; // Load measurements
  int mismatches; // Failed compares
  int samples_checked; // Compares made
  logic [31:0] q; // Read data
  // ****
  // Design and load
  // ****
  ocmp_channel dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .avs_req(req),
    .avs_rsp(rsp),
    .compare_output_pin(pin),
    .channel_irq(irq)
  );
  ocmp_load load (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin(pin),
    .irq(irq),
    .edges(edges),
    .gap(gap),
    .irq_lag(irq_lag)
  );
  // Clock, 10 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ****
  // Report and compare
  // ****
  task give_verdict;
    begin
      if (mismatches == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task fail_wait(input string what);
    begin
      mismatches++;
      $display("ERROR %0t wait ran out: %s", $time, what);
      give_verdict;
    end
  endtask
  task check_bit(input logic got, input logic exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        mismatches++;
        $display("ERROR %0t bit %b expected %b", $time, got, exp);
      end
    end
  endtask
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        mismatches++;
        $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check_num(input int got, input int exp);
    begin
      samples_checked++;
      if (got != exp)
      begin
        mismatches++;
        $display("ERROR %0t cycles %0d expected %0d", $time, got, exp);
      end
    end
  endtask
  // ****
  // Bus and wait helpers; all end at a falling edge
  // ****
  task bus_xfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk_sys);
      req <= '{read: rd, write: !rd, address: a, writedata: d};
      // Hold until waitrequest is seen low at a rising edge
      do
      begin
        @(posedge clk_sys);
        n++;
        if (n > 40)
          fail_wait("bus");
      end
      while (rsp.waitrequest !== 1'b0);
      // Read data taken at that same edge, then release
      q = rsp.readdata;
      req <= '0;
      @(negedge clk_sys);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus_xfer(1'b0, a, d);
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    begin
      bus_xfer(1'b1, a, 32'h00000000);
      check_word(q, exp);
    end
  endtask
  task idle(input int n);
    begin
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task wait_edge;
    int e0, n;
    begin
      e0 = edges;
      n = 0;
      while (edges == e0)
      begin
        @(negedge clk_sys);
        n++;
        if (n > 400)
          fail_wait("pin");
      end
    end
  endtask
  task wait_irq;
    int n;
    begin
      n = 0;
      while (irq !== 1'b1)
      begin
        @(negedge clk_sys);
        n++;
        if (n > 40)
          fail_wait("irq");
      end
      // Load updates its lag one edge after it sees the request
      idle(1);
      check_num(irq_lag, `OCMP_FLAG_LAG * `OCMP_TCY_DIV);
    end
  endtask
  function automatic logic [31:0] cw(input logic ie, input logic ts, input ocmp_mode_t m);
    cw = {27'h0000000, ie, ts, m};
  endfunction
  // ****
  // Scenarios
  // ****
  task t_toggle;
    begin
      wr(`OCMP_ADDR_TCTL, 32'h0000000C);
      wr(`OCMP_ADDR_PER0, 32'h00000005);
      wr(`OCMP_ADDR_PRI, 32'h00000002);
      wr(`OCMP_ADDR_CTRL, cw(1'b1, 1'b0, OCMP_TOGGLE));
      idle(5);
      check_bit(pin, 1'b0);
      wr(`OCMP_ADDR_TCTL, 32'h00000001);
      wait_edge;
      check_bit(pin, 1'b1);
      wait_irq;
      wr(`OCMP_ADDR_STAT, 32'h00000001);
      idle(2);
      check_bit(irq, 1'b0);
      wait_edge;
      check_bit(pin, 1'b0);
      check_num(gap, 24);
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_TOGGLE));
      wait_edge;
      idle(12);
      check_bit(irq, 1'b0);
      bus_xfer(1'b1, `OCMP_ADDR_STAT, 32'h00000000);
      check_word(q & 32'h00000001, 32'h00000001);
    end
  endtask
  task t_init_modes;
    begin
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_OFF));
      idle(5);
      check_bit(pin, 1'b0);
      wr(`OCMP_ADDR_TCTL, 32'h0000000C);
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_LOW));
      idle(5);
      check_bit(pin, 1'b1);
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_TOGGLE));
      idle(5);
      check_bit(pin, 1'b1);
      wr(`OCMP_ADDR_TCTL, 32'h00000001);
      wait_edge;
      check_bit(pin, 1'b0);
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_OFF));
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_HIGH));
      idle(5);
      check_bit(pin, 1'b0);
      wait_edge;
      check_bit(pin, 1'b1);
    end
  endtask
  task t_single;
    int e;
    begin
      // Software order: values, period, mode, then run
      wr(`OCMP_ADDR_TCTL, 32'h0000000C);
      wr(`OCMP_ADDR_PRI, 32'h00000004);
      wr(`OCMP_ADDR_SEC, 32'h00000009);
      wr(`OCMP_ADDR_PER1, 32'h00000014);
      // Old flag must be gone before the enable goes up
      wr(`OCMP_ADDR_STAT, 32'h00000001);
      wr(`OCMP_ADDR_CTRL, cw(1'b1, 1'b1, OCMP_SINGLE));
      idle(5);
      check_bit(pin, 1'b0);
      wr(`OCMP_ADDR_TCTL, 32'h00000002);
      wait_edge;
      check_bit(pin, 1'b1);
      wait_edge;
      check_bit(pin, 1'b0);
      check_num(gap, 20);
      wait_irq;
      e = edges;
      idle(100);
      check_num(edges, e);
      wr(`OCMP_ADDR_STAT, 32'h00000001);
      wr(`OCMP_ADDR_CTRL, cw(1'b1, 1'b1, OCMP_SINGLE));
      wait_edge;
      wait_edge;
      check_num(gap, 20);
      // Stopped first timer selected: no pulse
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b0, OCMP_SINGLE));
      e = edges;
      idle(100);
      check_num(edges, e);
    end
  endtask
  task t_no_fall;
    int e;
    begin
      wr(`OCMP_ADDR_TCTL, 32'h0000000A);
      wr(`OCMP_ADDR_PER1, 32'h00000006);
      wr(`OCMP_ADDR_PRI, 32'h00000003);
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b1, OCMP_SINGLE));
      wait_edge;
      check_bit(pin, 1'b1);
      e = edges;
      idle(100);
      check_num(edges, e);
      wr(`OCMP_ADDR_CTRL, cw(1'b0, 1'b1, OCMP_SINGLE));
      idle(5);
      check_bit(pin, 1'b0);
      wait_edge;
      wr(`OCMP_ADDR_SEC, 32'h00000005);
      wait_edge;
      check_bit(pin, 1'b0);
    end
  endtask
  task t_reset;
    begin
      // Pin high and request up, then reset in mid-run
      wr(`OCMP_ADDR_CTRL, cw(1'b1, 1'b0, OCMP_LOW));
      idle(2);
      check_bit(pin, 1'b1);
      check_bit(irq, 1'b1);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      idle(2);
      check_bit(pin, 1'b0);
      check_bit(irq, 1'b0);
      @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      rd_chk(`OCMP_ADDR_CTRL, 32'h00000000);
      rd_chk(`OCMP_ADDR_STAT, 32'h00000000);
    end
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    req = '0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    check_bit(pin, 1'b0);
    check_bit(irq, 1'b0);
    check_bit(rsp.waitrequest, 1'b1);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    rd_chk(`OCMP_ADDR_PER0, 32'h0000FFFF);
    rd_chk(`OCMP_ADDR_CTRL, 32'h00000000);
    rd_chk(`OCMP_ADDR_STAT, 32'h00000000);
    rd_chk(4'hF, 32'h00000000);
    t_toggle;
    t_init_modes;
    t_single;
    t_no_fall;
    t_reset;
    give_verdict;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_wait("run");
  end
endmodule

// ### rtl/ocmp_channel.sv
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "ocmp_defines.svh"
module ocmp_channel (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire ocmp_pkg::ocmp_req_t avs_req,
  output ocmp_pkg::ocmp_rsp_t avs_rsp,
  // Pin and interrupt
  output logic compare_output_pin,
  output logic channel_irq
);
  import ocmp_pkg::*;

  // ****************************************************
  // Instruction clock and time bases
  // ****************************************************
  logic tick; // Instruction clock enable
  logic [15:0] time_base_period [2]; // Period per timer
  logic [15:0] time_base_count [2]; // Count per timer
  logic [1:0] timer_run_bit; // Run bit per timer
  logic [1:0] timer_clear; // Clear pulse per timer

  ocmp_tick u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(tick)
  );

  // One time base per timer
  for (genvar g = 0; g < 2; g++)
  begin : g_tb
    ocmp_timer u_timer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick(tick),
      .run(timer_run_bit[g]),
      .clear(timer_clear[g]),
      .period(time_base_period[g]),
      .count(time_base_count[g])
    );
  end

  // ****************************************************
  // Registers
  // ****************************************************
  ocmp_mode_t compare_mode_field; // Mode field
  logic time_base_select; // Timer select
  logic channel_irq_enable; // Interrupt enable
  logic [15:0] primary_compare_value; // Rising edge value
  logic [15:0] secondary_compare_value; // Falling edge value
  logic channel_irq_flag; // Sticky event flag
  logic mode_wr; // Control word written this cycle
  logic flag_clr; // Software flag clear
  logic [31:0] next_readdata;
  logic next_waitrequest;

  // Register write accepted at the given address
  function automatic logic is_wr(input ocmp_req_t r, input logic [3:0] a);
    return r.write && avs_rsp.waitrequest == 1'b0 && r.address == a;
  endfunction

  // Bus answer: one wait cycle, then accept
  always_comb
  begin
    next_waitrequest = 1'b1;
    next_readdata = avs_rsp.readdata;
    if ((avs_req.read || avs_req.write) && avs_rsp.waitrequest)
    begin
      next_waitrequest = 1'b0;
      unique case (avs_req.address)
        `OCMP_ADDR_CTRL: next_readdata = {27'h0, channel_irq_enable, time_base_select,
                                          compare_mode_field};
        `OCMP_ADDR_PRI: next_readdata = {16'h0, primary_compare_value};
        `OCMP_ADDR_SEC: next_readdata = {16'h0, secondary_compare_value};
        `OCMP_ADDR_PER0: next_readdata = {16'h0, time_base_period[0]};
        `OCMP_ADDR_PER1: next_readdata = {16'h0, time_base_period[1]};
        `OCMP_ADDR_TCTL: next_readdata = {30'h0, timer_run_bit};
        `OCMP_ADDR_STAT: next_readdata = {30'h0, compare_output_pin, channel_irq_flag};
        `OCMP_ADDR_CNT0: next_readdata = {16'h0, time_base_count[0]};
        `OCMP_ADDR_CNT1: next_readdata = {16'h0, time_base_count[1]};
        default: next_readdata = 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  assign mode_wr = is_wr(avs_req, `OCMP_ADDR_CTRL);
  assign flag_clr = is_wr(avs_req, `OCMP_ADDR_STAT) && avs_req.writedata[`OCMP_FLAG_BIT];
  assign timer_clear[0] = is_wr(avs_req, `OCMP_ADDR_TCTL) && avs_req.writedata[`OCMP_CLR0_BIT];
  assign timer_clear[1] = is_wr(avs_req, `OCMP_ADDR_TCTL) && avs_req.writedata[`OCMP_CLR1_BIT];

  // Register file storage
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_rsp <= '{readdata: 32'h00000000, waitrequest: 1'b1};
      compare_mode_field <= OCMP_OFF;
      time_base_select <= 1'b0; // First timer by default
      channel_irq_enable <= 1'b0;
      primary_compare_value <= `OCMP_RST_WORD;
      secondary_compare_value <= `OCMP_RST_WORD;
      time_base_period[0] <= `OCMP_RST_PER;
      time_base_period[1] <= `OCMP_RST_PER;
      timer_run_bit <= 2'h0;
    end
    else
    begin
      avs_rsp <= '{readdata: next_readdata, waitrequest: next_waitrequest};
      if (mode_wr)
      begin
        compare_mode_field <= ocmp_mode_t'(avs_req.writedata[2:0]);
        time_base_select <= avs_req.writedata[`OCMP_TSEL_BIT];
        channel_irq_enable <= avs_req.writedata[`OCMP_IE_BIT];
      end
      if (is_wr(avs_req, `OCMP_ADDR_PRI))
        primary_compare_value <= avs_req.writedata[15:0];
      if (is_wr(avs_req, `OCMP_ADDR_SEC))
        secondary_compare_value <= avs_req.writedata[15:0];
      if (is_wr(avs_req, `OCMP_ADDR_PER0))
        time_base_period[0] <= avs_req.writedata[15:0];
      if (is_wr(avs_req, `OCMP_ADDR_PER1))
        time_base_period[1] <= avs_req.writedata[15:0];
      if (is_wr(avs_req, `OCMP_ADDR_TCTL))
        timer_run_bit <= avs_req.writedata[1:0];
    end
  end

  // ****************************************************
  // Compare engine
  // ****************************************************
  logic [15:0] sel_count; // Compared count
  logic sel_run; // Compared timer runs
  logic pri_match; // Primary equality
  logic sec_match; // Secondary equality
  logic pend_set; // Output goes high next tick
  logic pend_clr; // Output goes low next tick
  logic pend_tog; // Output inverts next tick
  logic done; // Single pulse finished
  logic [1:0] lag; // Flag delay shift, one bit per tick
  logic next_pin, next_pend_set, next_pend_clr, next_pend_tog, next_done;
  logic [1:0] next_lag;
  logic next_flag, next_irq;
  logic edge_ev; // Flag-worthy output edge this tick

  // Select timer
  assign sel_count = time_base_select ? time_base_count[1] : time_base_count[0];
  assign sel_run = time_base_select ? timer_run_bit[1] : timer_run_bit[0];
  // Exact match sampled on the instruction clock
  assign pri_match = tick && sel_run && (sel_count == primary_compare_value);
  // Secondary never matches while it exceeds the period
  assign sec_match = tick && sel_run && (sel_count == secondary_compare_value);

  // Next output state
  always_comb
  begin
    next_pin = compare_output_pin;
    next_pend_set = pend_set;
    next_pend_clr = pend_clr;
    next_pend_tog = pend_tog;
    next_done = done;
    next_lag = lag;
    edge_ev = 1'b0;
    // Apply matches pending from the last tick
    if (tick)
    begin
      if (pend_tog)
      begin
        next_pin = !compare_output_pin;
        edge_ev = 1'b1;
      end
      else if (pend_set)
        next_pin = 1'b1;
      else if (pend_clr)
      begin
        next_pin = 1'b0;
        edge_ev = (compare_mode_field != OCMP_LOW);
      end
      if (pend_set && compare_mode_field != OCMP_HIGH && compare_mode_field != OCMP_TOGGLE)
        edge_ev = 1'b0;
      if (pend_set && compare_mode_field == OCMP_HIGH)
        edge_ev = 1'b1;
      if (pend_clr && compare_mode_field == OCMP_LOW)
        edge_ev = 1'b1;
      next_pend_set = 1'b0;
      next_pend_clr = 1'b0;
      next_pend_tog = 1'b0;
      next_lag = {lag[0], edge_ev};
    end
    // Capture matches for the next tick
    unique case (compare_mode_field)
      OCMP_HIGH: if (pri_match) next_pend_set = 1'b1;
      OCMP_LOW: if (pri_match) next_pend_clr = 1'b1;
      OCMP_TOGGLE: if (pri_match) next_pend_tog = 1'b1;
      OCMP_SINGLE, OCMP_CONT:
      begin
        if (sec_match && (compare_output_pin || pend_set))
          next_pend_clr = 1'b1;
        else if (pri_match && !done)
          next_pend_set = 1'b1;
        if (tick && pend_clr && compare_mode_field == OCMP_SINGLE)
          next_done = 1'b1; // Stay low after the pulse
      end
      default: ;
    endcase
    // Mode write overrides pending work
    if (mode_wr)
    begin
      next_pend_set = 1'b0;
      next_pend_clr = 1'b0;
      next_pend_tog = 1'b0;
      next_done = 1'b0; // Re-arm
      unique case (ocmp_mode_t'(avs_req.writedata[2:0]))
        OCMP_OFF: next_pin = 1'b0;
        OCMP_HIGH: next_pin = 1'b0;
        OCMP_LOW: next_pin = 1'b1;
        OCMP_TOGGLE: next_pin = compare_output_pin; // Keep prior level
        OCMP_SINGLE, OCMP_CONT: next_pin = 1'b0;
        default: next_pin = 1'b0;
      endcase
    end
    // Flag: hardware set wins over software clear
    next_flag = (channel_irq_flag && !flag_clr) || (tick && lag[1]);
    next_irq = next_flag && channel_irq_enable;
  end

  // Register output state
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      compare_output_pin <= 1'b0;
      pend_set <= 1'b0;
      pend_clr <= 1'b0;
      pend_tog <= 1'b0;
      done <= 1'b0;
      lag <= 2'h0;
      channel_irq_flag <= 1'b0;
      channel_irq <= 1'b0;
    end
    else
    begin
      compare_output_pin <= next_pin;
      pend_set <= next_pend_set;
      pend_clr <= next_pend_clr;
      pend_tog <= next_pend_tog;
      done <= next_done;
      lag <= next_lag;
      channel_irq_flag <= next_flag;
      channel_irq <= next_irq;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_toggle_after_match: assert property (
    pri_match && compare_mode_field == OCMP_TOGGLE && !pend_tog && !mode_wr ##1 !mode_wr [*4]
    |=> compare_output_pin != $past(compare_output_pin, 5))
    else $error("toggle missed");
  a_toggle_keeps_level: assert property (
    mode_wr && avs_req.writedata[2:0] == 3'h3 |=> compare_output_pin == $past(compare_output_pin))
    else $error("toggle entry changed level");
  a_single_init_low: assert property (
    mode_wr && avs_req.writedata[2:0] == 3'h4 |=> !compare_output_pin)
    else $error("single pulse not low");
  a_flag_two_ticks: assert property (
    tick && pend_tog && compare_mode_field == OCMP_TOGGLE
    |-> ##9 channel_irq_flag)
    else $error("flag late after toggle");
  a_irq_gated: assert property (
    channel_irq |-> $past(channel_irq_enable))
    else $error("irq without enable");
  a_single_stays_low: assert property (
    done && compare_mode_field == OCMP_SINGLE && !mode_wr |=> !compare_output_pin)
    else $error("single pulse repeated");
  a_count_wraps: assert property (
    tick && timer_run_bit[0] && !timer_clear[0] && time_base_count[0] == time_base_period[0]
    |=> time_base_count[0] == 16'h0000)
    else $error("time base did not wrap");
  a_reset_low: assert property (
    $rose(reset_n) |-> !compare_output_pin)
    else $error("pin not low after reset");

  c_toggle: cover property (tick && pend_tog);
  c_pulse_fall: cover property (tick && pend_clr && compare_mode_field == OCMP_SINGLE);
  c_irq: cover property (channel_irq);
endmodule

// ### rtl/ocmp_defines.svh
`ifndef OCMP_DEFINES_SVH
`define OCMP_DEFINES_SVH
// Register word addresses
`define OCMP_ADDR_CTRL 4'h0
`define OCMP_ADDR_PRI 4'h1
`define OCMP_ADDR_SEC 4'h2
`define OCMP_ADDR_PER0 4'h3
`define OCMP_ADDR_PER1 4'h4
`define OCMP_ADDR_TCTL 4'h5
`define OCMP_ADDR_STAT 4'h6
`define OCMP_ADDR_CNT0 4'h7
`define OCMP_ADDR_CNT1 4'h8
// Control word fields
`define OCMP_MODE_LSB 0
`define OCMP_TSEL_BIT 3
`define OCMP_IE_BIT 4
// Timer control fields
`define OCMP_RUN0_BIT 0
`define OCMP_RUN1_BIT 1
`define OCMP_CLR0_BIT 2
`define OCMP_CLR1_BIT 3
// Status fields
`define OCMP_FLAG_BIT 0
`define OCMP_PIN_BIT 1
// Reset values
`define OCMP_RST_WORD 16'h0000
`define OCMP_RST_PER 16'hFFFF
// Instruction clock: 10 ns system clock, 40 ns instruction period
`define OCMP_TCY_NS 40
`define OCMP_CLK_NS 10
`define OCMP_TCY_DIV (`OCMP_TCY_NS / `OCMP_CLK_NS)
// Flag lag after the output edge, instruction clocks
`define OCMP_FLAG_LAG 2
`endif

// ### rtl/ocmp_pkg.sv
package ocmp_pkg;
  // Compare mode field codes
  typedef enum logic [2:0] {
    OCMP_OFF = 3'h0,
    OCMP_HIGH = 3'h1,
    OCMP_LOW = 3'h2,
    OCMP_TOGGLE = 3'h3,
    OCMP_SINGLE = 3'h4,
    OCMP_CONT = 3'h5,
    OCMP_PWM = 3'h6,
    OCMP_PWMF = 3'h7
  } ocmp_mode_t;
  // Avalon-MM request group
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } ocmp_req_t;
  // Avalon-MM answer group
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ocmp_rsp_t;
endpackage

// ### rtl/ocmp_tick.sv
`timescale 1ns/1ps
`include "ocmp_defines.svh"
// ****************************************************
// Instruction clock enable divider
// ****************************************************
module ocmp_tick #(
  parameter int DIV = `OCMP_TCY_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Enable pulse
  output logic tick
);
  logic [7:0] cnt; // Divider count
  logic [7:0] next_cnt;
  logic next_tick;
  // Next divider state
  always_comb
  begin
    next_tick = (cnt == 8'(DIV - 1));
    next_cnt = next_tick ? 8'h00 : cnt + 8'h01;
  end
  // Register divider
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ### rtl/ocmp_timer.sv
`timescale 1ns/1ps
`include "ocmp_defines.svh"
// ****************************************************
// 16-bit up-counting time base
// ****************************************************
module ocmp_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [W-1:0] period,
  // Count
  output logic [W-1:0] count
);
  logic [W-1:0] next_count;
  // Count to period, then zero on the next instruction clock
  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = '0;
    else if (tick && run)
      next_count = (count == period) ? '0 : count + W'(1);
  end
  // Register count
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else
      count <= next_count;
  end
endmodule
